// ---- rtl/amp_fault_pkg.sv ----
// Constants, register map and carrier types for the amplifier fault supervisor.
// Assumes one 10 MHz clock and a plain register port with one-cycle read data.
// Functional notes
// - Hall code 000 or 111 is illegal at 120 degrees
// - Status query takes selector 0..3, eight bits
// - Selector 0 reports supply, current, temperature faults
// - Selector 1 reports Hall error per axis
// - Selector 2 reports continuous current exceeded
// - Selector 3 reports emergency power cut
// - Status reads never alter fault state
// - Handled fault diverts thread zero to handler
// - Raw Hall states readable separately
// - Hall error disables amplifier when off-on-error set
// - Under-voltage disables, recovers automatically
// - Under-voltage at power-up triggers handler
// - Over-voltage disables, hysteresis 92 to 90 volts
// - Over-voltage never latches nor calls handler
// - Axis pair over-current disables amplifier
// - Over-current recovery needs servo-here or reset
// - Over-current shutdown ignores off-on-error and handler
// - Over-temperature disables and triggers handler
// - Over-temperature recovery needs servo-here or reset
// - Power cut forces motor-off; motor-off then servo-here
// - Brush or external axes skip Hall checking
package amp_fault_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_QUERY0 = 8'h00; // Supply, current, temperature
    localparam logic [7:0] OFS_QUERY1 = 8'h04; // Hall errors per axis
    localparam logic [7:0] OFS_QUERY2 = 8'h08; // Continuous current exceeded
    localparam logic [7:0] OFS_QUERY3 = 8'h0c; // Emergency power cut
    localparam logic [7:0] OFS_HALL_STATE = 8'h10; // Raw Hall inputs
    localparam logic [7:0] OFS_CONFIG = 8'h14; // Configuration
    localparam logic [7:0] OFS_COMMAND = 8'h18; // Write-only commands
    localparam logic [7:0] OFS_STATUS = 8'h1c; // Enable and handler state
    // Configuration field positions
    localparam int CFG_OE_LSB = 0; // Off-on-error, one bit per axis
    localparam int CFG_BRUSH_LSB = 4; // Brush axis select, one bit per axis
    localparam int CFG_PHASE120 = 8; // 120 degree Hall phasing
    localparam int CFG_HANDLER = 9; // Handler label present
    localparam int CFG_THREAD0 = 10; // Program running in thread zero
    localparam int CFG_W = 11;
    localparam logic [10:0] CFG_RESET = 11'h100; // 120 degree phasing, rest off
    // Command bit positions
    localparam int CMD_SERVO_HERE = 0;
    localparam int CMD_MOTOR_OFF = 1;
    localparam int CMD_RESET = 2;
    localparam int CMD_HANDLER_ACK = 3;
    // Selector 0 bit positions
    localparam int Q0_UNDER_VOLT = 0;
    localparam int Q0_OVER_VOLT = 1;
    localparam int Q0_OC_PAIR0 = 2;
    localparam int Q0_OC_PAIR1 = 3;
    localparam int Q0_OVER_TEMP = 4;
    // Selector 3 value from the power cut until its recovery completes
    localparam logic [7:0] Q3_CUT_VALUE = 8'h03;
    // Hall codes that cannot occur with 120 degree phasing
    localparam logic [2:0] HALL_ALL_LOW = 3'h0;
    localparam logic [2:0] HALL_ALL_HIGH = 3'h7;

    // Fault inputs travelling together through the synchroniser
    typedef struct packed {
        logic [11:0] hall; // Three Hall lines per axis, axis 0 lowest
        logic under_volt; // Supply below 18 V
        logic ov_above; // Supply above 92 V
        logic ov_below; // Supply below 90 V
        logic [1:0] over_current; // Pair current above 20 A
        logic over_temp; // Heat sink above 80 C
        logic [3:0] cont_exceed; // Continuous current setting exceeded
        logic power_cut; // Emergency power cut input
    } fault_in_t;

    // Power cut recovery states
    typedef enum logic [1:0] {
        CUT_IDLE = 2'b00,
        CUT_TRIPPED = 2'b01,
        CUT_MO_SEEN = 2'b10
    } cut_state_t;
endpackage : amp_fault_pkg

// ---- rtl/fault_sync.sv ----
// Two-flop synchroniser for the fault input bundle.
// Assumes inputs come from pins outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module fault_sync
    import amp_fault_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire fault_in_t raw,
    output fault_in_t synced
);
    fault_in_t stage1; // First stage, read only by the second
    fault_in_t next_stage1; // Next first stage
    fault_in_t next_synced; // Next second stage

    // Shift one stage per clock
    always_comb begin
        next_stage1 = raw;
        next_synced = stage1;
    end

    // Stage registers, cleared at reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= next_stage1;
            synced <= next_synced;
        end
    end
endmodule : fault_sync
`default_nettype wire

// ---- rtl/amp_fault_monitor.sv ----
// Amplifier fault supervisor: latches faults, gates the amplifier enable,
// requests the fault handler and serves the status query registers.
// Assumes fault flags arrive as asynchronous pin levels from analog comparators.
`timescale 1ns/1ps
`default_nettype none
module amp_fault_monitor
    import amp_fault_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [11:0] hall_in,
    input wire logic under_volt_in,
    input wire logic over_volt_hi_in,
    input wire logic over_volt_lo_in,
    input wire logic [1:0] over_current_in,
    input wire logic over_temp_in,
    input wire logic [3:0] cont_exceed_in,
    input wire logic emergency_power_cut_input,
    output logic amp_enable,
    output logic amp_fault_handler
);
    // Illegal Hall code check for one axis
    function automatic logic hall_illegal(input logic [2:0] code);
        hall_illegal = (code == HALL_ALL_LOW) || (code == HALL_ALL_HIGH);
    endfunction : hall_illegal

    fault_in_t raw; // Pin bundle
    fault_in_t s; // Synchronised bundle

    // Gather pins into the carrier
    always_comb begin
        raw.hall = hall_in;
        raw.under_volt = under_volt_in;
        raw.ov_above = over_volt_hi_in;
        raw.ov_below = over_volt_lo_in;
        raw.over_current = over_current_in;
        raw.over_temp = over_temp_in;
        raw.cont_exceed = cont_exceed_in;
        raw.power_cut = emergency_power_cut_input;
    end

    // Two flops before any logic sees the pins
    fault_sync u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .raw(raw),
        .synced(s)
    );

    // Register file state
    logic [CFG_W-1:0] cfg; // Configuration word
    logic [CFG_W-1:0] next_cfg;
    logic [31:0] next_rdata;
    // Fault state
    logic [3:0] hall_err; // Sticky Hall error per axis
    logic [3:0] next_hall_err;
    logic ov; // Over-voltage with hysteresis
    logic next_ov;
    logic [1:0] oc_l; // Latched over-current per pair
    logic [1:0] next_oc_l;
    logic ot_l; // Latched over-temperature
    logic next_ot_l;
    logic uv_q; // Under-voltage one cycle ago
    cut_state_t cut; // Power cut recovery state
    cut_state_t next_cut;
    logic servo_on; // Servo requested by host
    logic next_servo_on;
    logic next_amp_enable;
    logic next_handler;
    // Decoded strobes and derived terms
    logic servo_here, motor_off, rst_cmd, ack; // Command pulses
    logic [3:0] hall_now; // Illegal code this cycle
    logic [1:0] warm; // Fills with ones once the synchroniser holds real pin samples
    logic [1:0] next_warm;
    logic hall_off; // Hall error with off-on-error
    logic trig; // Handled fault event
    logic [7:0] q0; // Selector 0 word

    // Command decode, one-cycle pulses from the write strobe
    always_comb begin
        servo_here = wr && (addr == OFS_COMMAND) && wdata[CMD_SERVO_HERE];
        motor_off = wr && (addr == OFS_COMMAND) && wdata[CMD_MOTOR_OFF];
        rst_cmd = wr && (addr == OFS_COMMAND) && wdata[CMD_RESET];
        ack = wr && (addr == OFS_COMMAND) && wdata[CMD_HANDLER_ACK];
    end

    // Configuration write
    always_comb begin
        next_cfg = cfg;
        if (wr && (addr == OFS_CONFIG)) begin
            next_cfg = wdata[CFG_W-1:0];
        end
    end

    // Hall checking per axis
    always_comb begin
        // Synchroniser resets to code 000, which would look illegal
        next_warm = {warm[0], 1'b1};
        for (int i = 0; i < 4; i++) begin
            // Brush or external axes are not checked
            hall_now[i] = hall_illegal(s.hall[3*i +: 3]) && cfg[CFG_PHASE120] && warm[1]
                && !cfg[CFG_BRUSH_LSB + i];
        end
        hall_off = |(hall_err & cfg[CFG_OE_LSB +: 4]);
    end

    // Fault latches; a new fault wins over a clearing command
    always_comb begin
        // Sticky Hall errors cleared by servo-here or reset
        next_hall_err = hall_now | (hall_err & {4{!(servo_here || rst_cmd)}});
        // Hysteresis: set above 92 V, clear below 90 V
        next_ov = ov;
        if (s.ov_above) begin
            next_ov = 1'b1;
        end else if (s.ov_below) begin
            next_ov = 1'b0;
        end
        // Over-current holds until it ends and servo-here or reset
        for (int p = 0; p < 2; p++) begin
            next_oc_l[p] = s.over_current[p] || (oc_l[p] && !servo_here && !rst_cmd);
        end
        // Over-temperature holds until it drops and servo-here or reset
        next_ot_l = s.over_temp || (ot_l && !servo_here && !rst_cmd);
    end

    // Power cut recovery sequence
    always_comb begin
        next_cut = cut;
        case (cut)
            CUT_IDLE: begin
                if (s.power_cut) begin
                    next_cut = CUT_TRIPPED;
                end
            end
            CUT_TRIPPED: begin
                if (s.power_cut) begin
                    next_cut = CUT_TRIPPED;
                end else if (rst_cmd) begin
                    next_cut = CUT_IDLE;
                end else if (motor_off) begin
                    next_cut = CUT_MO_SEEN;
                end
            end
            CUT_MO_SEEN: begin
                if (s.power_cut) begin
                    next_cut = CUT_TRIPPED;
                end else if (servo_here || rst_cmd) begin
                    next_cut = CUT_IDLE;
                end
            end
            default: begin
                next_cut = CUT_TRIPPED;
            end
        endcase
    end

    // Servo request and amplifier enable
    always_comb begin
        next_servo_on = servo_on;
        if (s.power_cut || (cut == CUT_TRIPPED) || rst_cmd || motor_off) begin
            next_servo_on = 1'b0;
        end else if (servo_here) begin
            next_servo_on = 1'b1;
        end
        // Every disabling condition gates the enable
        next_amp_enable = servo_on && !s.under_volt
            && !ov
            && !(|oc_l)
            && !ot_l
            && (cut == CUT_IDLE)
            && !hall_off;
    end

    // Handler request on handled faults; over-voltage and over-current excluded
    always_comb begin
        trig = (|(hall_now & ~hall_err))
            || (s.under_volt && !uv_q)
            || (s.over_temp && !ot_l)
            || (s.power_cut && (cut != CUT_TRIPPED));
        // New request wins over acknowledge
        next_handler = (trig && cfg[CFG_HANDLER] && cfg[CFG_THREAD0])
            || (amp_fault_handler && !ack);
    end

    // Selector words and read mux; reading changes nothing
    always_comb begin
        q0 = '0;
        q0[Q0_UNDER_VOLT] = s.under_volt;
        q0[Q0_OVER_VOLT] = ov;
        q0[Q0_OC_PAIR0] = oc_l[0];
        q0[Q0_OC_PAIR1] = oc_l[1];
        q0[Q0_OVER_TEMP] = ot_l;
        next_rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                OFS_QUERY0: next_rdata = {24'h00_0000, q0};
                OFS_QUERY1: next_rdata = {28'h000_0000, hall_err};
                OFS_QUERY2: next_rdata = {28'h000_0000, s.cont_exceed};
                OFS_QUERY3: next_rdata = {24'h00_0000,
                    (cut != CUT_IDLE) ? Q3_CUT_VALUE : 8'h00};
                OFS_HALL_STATE: next_rdata = {20'h0_0000, s.hall};
                OFS_CONFIG: next_rdata = {21'h00_0000, cfg};
                OFS_STATUS: next_rdata = {29'h0000_0000, servo_on,
                    amp_fault_handler, amp_enable};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg <= CFG_RESET;
            rdata <= 32'h0000_0000;
            hall_err <= 4'h0;
            ov <= 1'b0;
            oc_l <= 2'h0;
            ot_l <= 1'b0;
            uv_q <= 1'b0;
            warm <= 2'b00;
            cut <= CUT_IDLE;
            servo_on <= 1'b0;
            amp_enable <= 1'b0;
            amp_fault_handler <= 1'b0;
        end else begin
            cfg <= next_cfg;
            rdata <= next_rdata;
            hall_err <= next_hall_err;
            ov <= next_ov;
            oc_l <= next_oc_l;
            ot_l <= next_ot_l;
            uv_q <= s.under_volt;
            warm <= next_warm;
            cut <= next_cut;
            servo_on <= next_servo_on;
            amp_enable <= next_amp_enable;
            amp_fault_handler <= next_handler;
        end
    end

    // Checks on the fault logic
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_hall_flag_set: assert property (hall_now[0] |=> hall_err[0])
        else $error("Hall error not flagged");
    a_brush_no_hall: assert property ((cfg[CFG_BRUSH_LSB +: 4] & hall_now) == 4'h0)
        else $error("Hall check active on brush axis");
    a_uv_disable: assert property (s.under_volt |=> !amp_enable)
        else $error("Amplifier enabled under low supply");
    a_ov_hyst_hold: assert property (ov && !s.ov_below |=> ov)
        else $error("Over-voltage released above 90 V");
    a_oc_hold: assert property (oc_l[0] && !servo_here && !rst_cmd
        |=> oc_l[0] ##1 !amp_enable)
        else $error("Over-current latch released early");
    a_ot_disable: assert property ($rose(ot_l) |=> !amp_enable [*2])
        else $error("Amplifier enabled during over-temperature");
    a_cut_needs_mo: assert property (cut == CUT_TRIPPED && !motor_off && !rst_cmd
        |=> cut != CUT_IDLE)
        else $error("Power cut left without motor-off");
    a_query1_read: assert property (rd && addr == OFS_QUERY1
        |=> rdata == {28'h000_0000, $past(hall_err)})
        else $error("Selector 1 read wrong");
    a_read_pure: assert property (rd && !wr && !(|hall_now) && !s.over_temp
        && !(|s.over_current) |=> $stable(hall_err) && $stable(ot_l))
        else $error("Read altered fault state");
    a_handler_req: assert property (trig && cfg[CFG_HANDLER] && cfg[CFG_THREAD0]
        |=> amp_fault_handler)
        else $error("Handler not requested");
    a_ov_no_handler: assert property (!trig && !amp_fault_handler
        |=> !amp_fault_handler)
        else $error("Handler raised without handled fault");
endmodule : amp_fault_monitor
`default_nettype wire

// ---- test/amp_side_model.sv ----
// Far side of the supervisor: supply, pair currents, heat sink, Halls, power cut.
// Assumes the bench sets the analog values; pins change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module amp_side_model
    import amp_fault_pkg::*;
(
    input wire logic sys_clk,
    output fault_in_t pins
);
    int supply_v = 48; // Supply volts
    int pair_amps [2] = '{0, 0}; // Summed current per axis pair
    int sink_c = 25; // Heat sink temperature
    logic [11:0] hall_code = 12'h249; // Legal code 001 on every axis
    logic [3:0] cont = 4'h0; // Continuous limit flags per axis
    logic cut = 1'b0; // Power cut line
    // Known levels before the first edge
    initial pins = '0;
    // Comparators sampled onto the pins after each edge
    always @(posedge sys_clk) begin
        pins.hall <= hall_code;
        pins.under_volt <= (supply_v < 18);
        pins.ov_above <= (supply_v > 92);
        pins.ov_below <= (supply_v < 90);
        pins.over_current[0] <= (pair_amps[0] > 20);
        pins.over_current[1] <= (pair_amps[1] > 20);
        pins.over_temp <= (sink_c > 80);
        pins.cont_exceed <= cont;
        pins.power_cut <= cut;
    end
endmodule : amp_side_model
`default_nettype wire

// ---- test/testbench.sv ----
// Bench: reference model of the supervisor compared with the design after each step.
// Assumes the far-side model drives every fault pin; one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== 32'(e)) begin miscompares++; \
    $display("wrong value %s expected %0h seen %0h", n, 32'(e), g); end end
module testbench
    import amp_fault_pkg::*;
    ;
    logic sys_clk = 1'b0; // Bench clock
    logic arst_n = 1'b0; // Reset, active low
    logic [7:0] addr = 8'h00; // Register address
    logic [31:0] wdata = 32'h0; // Write data
    logic wr = 1'b0; // Write strobe
    logic rd = 1'b0; // Read strobe
    logic [31:0] rdata; // Read data
    logic amp_enable; // Amplifier enable
    logic amp_fault_handler; // Handler request
    fault_in_t pins; // Far-side pin levels
    int miscompares = 0; // Mismatch count
    int checks_done = 0; // Comparison count
    int ax; // Axis loop index
    int k; // Inner loop index
    // Reference state
    logic [31:0] cfg = 32'h100;
    logic [3:0] hall_l = 4'h0;
    int servo = 0, ov = 0, ot_l = 0, cut_st = 0, hdl = 0;
    int uv_now = 0, prev_uv = 0, prev_ot = 0, prev_cut = 0;
    int oc_l [2] = '{0, 0};
    int volts [6] = '{12, 48, 95, 91, 89, 48};
    logic [31:0] side_cfg [2] = '{32'h74f, 32'h60f};

    // Clock of 100 ns period
    always #50 sys_clk = ~sys_clk;

    amp_side_model u_amp_side_model (.sys_clk(sys_clk), .pins(pins));
    amp_fault_monitor u_amp_fault_monitor (
        .sys_clk(sys_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .hall_in(pins.hall), .under_volt_in(pins.under_volt),
        .over_volt_hi_in(pins.ov_above), .over_volt_lo_in(pins.ov_below),
        .over_current_in(pins.over_current), .over_temp_in(pins.over_temp),
        .cont_exceed_in(pins.cont_exceed), .emergency_power_cut_input(pins.power_cut),
        .amp_enable(amp_enable), .amp_fault_handler(amp_fault_handler));

    // One-cycle write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // One-cycle read, data taken in the following cycle
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Handler request only with handler and thread zero configured
    function automatic void raise();
        if (cfg[9] && cfg[10]) hdl = 1;
    endfunction : raise

    // Fold present pin levels into the reference latches
    function automatic void advance();
        logic [2:0] c;
        uv_now = int'(u_amp_side_model.supply_v < 18);
        if (uv_now && !prev_uv) raise();
        if (u_amp_side_model.supply_v > 92) ov = 1;
        else if (u_amp_side_model.supply_v < 90) ov = 0;
        for (int p = 0; p < 2; p++) begin
            if (u_amp_side_model.pair_amps[p] > 20) oc_l[p] = 1;
        end
        if (u_amp_side_model.sink_c > 80) begin
            if (!prev_ot) raise();
            ot_l = 1;
        end
        for (int i = 0; i < 4; i++) begin
            c = u_amp_side_model.hall_code[3*i +: 3];
            if (cfg[8] && !cfg[4+i] && (c == 3'h0 || c == 3'h7)) begin
                if (!hall_l[i]) raise();
                hall_l[i] = 1'b1;
            end
        end
        if (u_amp_side_model.cut) begin
            if (!prev_cut) raise();
            cut_st = 1;
            servo = 0;
        end
        prev_uv = uv_now;
        prev_ot = int'(u_amp_side_model.sink_c > 80);
        prev_cut = int'(u_amp_side_model.cut);
    endfunction : advance

    // Expected amplifier enable
    function automatic int exp_en();
        return int'(servo && !uv_now && !ov && !oc_l[0] && !oc_l[1] && !ot_l
            && ((hall_l & cfg[3:0]) == 4'h0) && cut_st == 0);
    endfunction : exp_en

    // Let pins settle, then compare every query and output
    task automatic settle_check();
        logic [31:0] v;
        repeat (5) @(posedge sys_clk);
        advance();
        rd_reg(OFS_QUERY0, v);
        `CHK("query0", uv_now + 2*ov + 4*oc_l[0] + 8*oc_l[1] + 16*ot_l, v)
        rd_reg(OFS_QUERY1, v);
        `CHK("query1", hall_l, v)
        rd_reg(OFS_QUERY2, v);
        `CHK("query2", u_amp_side_model.cont, v)
        rd_reg(OFS_QUERY3, v);
        `CHK("query3", (cut_st != 0) ? 3 : 0, v)
        rd_reg(OFS_HALL_STATE, v);
        `CHK("hall state", u_amp_side_model.hall_code, v)
        rd_reg(OFS_CONFIG, v);
        `CHK("config", cfg, v)
        rd_reg(OFS_STATUS, v);
        `CHK("status", exp_en() + 2*hdl + 4*servo, v)
        `CHK("amp_enable", exp_en(), amp_enable)
        `CHK("handler", hdl, amp_fault_handler)
    endtask : settle_check

    // Configuration write
    task automatic set_cfg(input logic [31:0] v);
        wr_reg(OFS_CONFIG, v);
        cfg = v;
        settle_check();
    endtask : set_cfg

    // Command write with its effect on the reference
    task automatic cmd(input int b);
        wr_reg(OFS_COMMAND, 32'h1 << b);
        if ((b == CMD_SERVO_HERE && cut_st != 1) || b == CMD_RESET) begin
            servo = int'(b == CMD_SERVO_HERE);
            cut_st = 0;
            ot_l = 0;
            oc_l = '{0, 0};
            hall_l = 4'h0;
        end
        if (b == CMD_MOTOR_OFF) begin
            servo = 0;
            if (cut_st == 1 && !u_amp_side_model.cut) cut_st = 2;
        end
        if (b == CMD_HANDLER_ACK) hdl = 0;
        settle_check();
    endtask : cmd

    task automatic test_end(input string n);
        $display("test %s ended, mismatches so far %0d", n, miscompares);
    endtask : test_end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin : main_seq
        logic [31:0] v;
        void'($urandom(32'h05fc));
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        settle_check();
        rd_reg(8'h20, v);
        `CHK("unmapped", 0, v)
        rd_reg(OFS_COMMAND, v);
        `CHK("command", 0, v)
        set_cfg(32'h70f);
        cmd(CMD_SERVO_HERE);
        test_end("reset and enable");
        // Both illegal codes on every axis
        for (ax = 0; ax < 4; ax++) begin
            for (k = 0; k < 2; k++) begin
                @(posedge sys_clk) u_amp_side_model.hall_code[3*ax +: 3] <= k ? 3'h7 : 3'h0;
                settle_check();
                @(posedge sys_clk) u_amp_side_model.hall_code[3*ax +: 3] <= 3'($urandom_range(6, 1));
                cmd(CMD_HANDLER_ACK);
                cmd(CMD_SERVO_HERE);
            end
        end
        // Brush axis and 60 degree phasing ignore illegal codes
        for (k = 0; k < 2; k++) begin
            set_cfg(side_cfg[k]);
            @(posedge sys_clk) u_amp_side_model.hall_code[8:6] <= 3'h7;
            settle_check();
            @(posedge sys_clk) u_amp_side_model.hall_code[8:6] <= 3'h2;
            settle_check();
            set_cfg(32'h70f);
        end
        test_end("hall");
        // Under-voltage, then over-voltage hysteresis
        for (k = 0; k < 6; k++) begin
            @(posedge sys_clk) u_amp_side_model.supply_v <= volts[k];
            settle_check();
        end
        cmd(CMD_HANDLER_ACK);
        test_end("supply");
        // Over-current with off-on-error clear
        set_cfg(32'h700);
        for (ax = 0; ax < 2; ax++) begin
            @(posedge sys_clk) u_amp_side_model.pair_amps[ax] <= 25;
            settle_check();
            @(posedge sys_clk) u_amp_side_model.pair_amps[ax] <= 3;
            settle_check();
            cmd(CMD_SERVO_HERE);
        end
        test_end("over-current");
        // Over-temperature, early servo-here refused
        @(posedge sys_clk) u_amp_side_model.sink_c <= 85;
        settle_check();
        cmd(CMD_SERVO_HERE);
        @(posedge sys_clk) u_amp_side_model.sink_c <= 60;
        settle_check();
        cmd(CMD_SERVO_HERE);
        cmd(CMD_HANDLER_ACK);
        test_end("over-temperature");
        // Controller reset clears a latch
        @(posedge sys_clk) u_amp_side_model.pair_amps[1] <= 30;
        settle_check();
        @(posedge sys_clk) u_amp_side_model.pair_amps[1] <= 0;
        settle_check();
        cmd(CMD_RESET);
        cmd(CMD_SERVO_HERE);
        test_end("reset command");
        // Power cut recovery order
        @(posedge sys_clk) u_amp_side_model.cut <= 1'b1;
        settle_check();
        @(posedge sys_clk) u_amp_side_model.cut <= 1'b0;
        cmd(CMD_SERVO_HERE);
        cmd(CMD_MOTOR_OFF);
        cmd(CMD_SERVO_HERE);
        cmd(CMD_HANDLER_ACK);
        test_end("power cut");
        // Random continuous-limit flags
        repeat (6) begin
            @(posedge sys_clk) u_amp_side_model.cont <= 4'($urandom);
            settle_check();
        end
        test_end("continuous");
        print_verdict();
    end

    // Hang guard, well beyond the expected run
    initial begin : watchdog
        #2000000;
        miscompares++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
